// >>> core/sep_core.v
// Serial EEPROM command port: frame decode, array, enable latch, busy
`include "sep_regs.vh"
`default_nettype none
module sep_core #(
   parameter PROG_CYCLES = `SEP_PROG_CYCLES,
   parameter DEPTH       = 128
) (
   // System clock and reset
   input  wire        clk_sys,
   input  wire        rst,
   // Serial pins
   input  wire        chip_select,
   input  wire        serial_clock,
   input  wire        serial_in,
   output reg         serial_out_o,
   output reg         serial_out_oe,
   // Strap, pull-up modelled by the pad
   input  wire        word_width_strap,
   // Status
   output reg         busy_o,
   output reg         prog_enabled_o
);
   localparam ST_IDLE = 5'b00001;
   localparam ST_CMD  = 5'b00010;
   localparam ST_DATA = 5'b00100;
   localparam ST_READ = 5'b01000;
   localparam ST_DONE = 5'b10000;

   localparam K_NONE  = 3'd0;
   localparam K_WRITE = 3'd1;
   localparam K_ERASE = 3'd2;
   localparam K_FILL  = 3'd3;
   localparam K_CLEAR = 3'd4;
   localparam K_EN    = 3'd5;
   localparam K_LOCK  = 3'd6;

   ////////////////////////////////////////////////////////////////////
   // Pin synchronisers
   wire [2:0] sync_w;
   sep_sync #(.W(3)) u_sync (
      .clk_sys  (clk_sys),
      .rst      (rst),
      .pin_in   ({chip_select, serial_clock, serial_in}),
      .pin_sync (sync_w)
   );
   wire cs_s = sync_w[2];
   wire sk_s = sync_w[1];
   wire di_s = sync_w[0];

   reg cs_d_r;
   reg sk_d_r;
   reg strap_m_r;
   reg strap_r;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         cs_d_r    <= 1'b0;
         sk_d_r    <= 1'b0;
         strap_m_r <= 1'b1;
         strap_r   <= 1'b1;
      end
      else
      begin
         cs_d_r    <= cs_s;
         sk_d_r    <= sk_s;
         strap_m_r <= word_width_strap;
         strap_r   <= strap_m_r;
      end
   end
   wire cs_rise = cs_s & ~cs_d_r;
   wire cs_fall = ~cs_s & cs_d_r;
   // Clock edges count only while selected
   wire sk_rise = sk_s & ~sk_d_r & cs_s;
   wire wide    = strap_r;

   ////////////////////////////////////////////////////////////////////
   // Storage array
   reg [15:0] mem_r [0:DEPTH-1];

   // Decodes an opcode and its two top address bits into a kind
   function [2:0] kind_of;
      input [1:0] op;
      input [1:0] top;
      begin
         case (op)
            `SEP_OP_WRITE: kind_of = K_WRITE;
            `SEP_OP_ERASE: kind_of = K_ERASE;
            `SEP_OP_READ:  kind_of = K_NONE;
            default:
               case (top)
                  `SEP_EXT_ENABLE: kind_of = K_EN;
                  `SEP_EXT_FILL:   kind_of = K_FILL;
                  `SEP_EXT_CLEAR:  kind_of = K_CLEAR;
                  default:         kind_of = K_LOCK;
               endcase
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Frame state
   reg [4:0]  state_r;
   reg [10:0] cmd_r;      // opcode then address, shifted in
   reg [3:0]  cnt_r;
   reg [15:0] data_r;
   reg [4:0]  dcnt_r;
   reg [2:0]  pend_r;     // instruction waiting for deselect
   reg [15:0] shout_r;
   reg        status_r;   // show ready/busy while selected
   reg [31:0] prog_cnt_r;
   reg [2:0]  prog_kind_r;
   reg [7:0]  prog_addr_r;
   reg [15:0] prog_data_r;

   wire [3:0] addr_bits = wide ? `SEP_ADDR_BITS_W : `SEP_ADDR_BITS_B;
   wire [4:0] data_bits = wide ? `SEP_DATA_BITS_W : `SEP_DATA_BITS_B;
   wire [1:0] op_w   = wide ? cmd_r[9:8] : cmd_r[10:9];
   wire [1:0] top_w  = wide ? cmd_r[7:6] : cmd_r[8:7];
   wire [10:0] cmd_n = {cmd_r[9:0], di_s};
   wire [1:0] op_n   = wide ? cmd_n[9:8] : cmd_n[10:9];
   wire [1:0] top_n  = wide ? cmd_n[7:6] : cmd_n[8:7];
   // Leading address bit dropped for addressed instructions
   wire [7:0] addr_n = wide ? {1'b0, cmd_n[6:0]} : cmd_n[7:0];
   wire [2:0] kind_n = kind_of(op_n, top_n);
   wire [15:0] rd_word = mem_r[addr_n[7:1]];
   wire [15:0] rd_val  = wide ? mem_r[addr_n[6:0]] :
                         (addr_n[0] ? {rd_word[15:8], 8'h00} :
                                      {rd_word[7:0], 8'h00});
   wire prog_busy = (prog_cnt_r != 32'd0);
   wire prog_kind = (pend_r == K_WRITE) | (pend_r == K_ERASE) |
                    (pend_r == K_FILL) | (pend_r == K_CLEAR);

   // Frame sequencer
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_r  <= ST_IDLE;
         cmd_r    <= 11'h000;
         cnt_r    <= 4'h0;
         data_r   <= 16'h0000;
         dcnt_r   <= 5'h00;
         pend_r   <= K_NONE;
         shout_r  <= 16'h0000;
      end
      else if (cs_rise | ~cs_s)
      begin
         // Fresh frame on every select; pending kept only for cs_fall
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
         dcnt_r  <= 5'h00;
         if (cs_rise)
            pend_r <= K_NONE;
      end
      else if (sk_rise)
      begin
         case (state_r)
            ST_IDLE:
               // Busy refuses new frames
               if (di_s & ~prog_busy)
               begin
                  state_r <= ST_CMD;
                  cmd_r   <= 11'h000;
                  cnt_r   <= 4'h0;
               end
            ST_CMD:
            begin
               cmd_r <= cmd_n;
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == addr_bits + 4'd1)
               begin
                  if (op_n == `SEP_OP_READ)
                  begin
                     shout_r <= rd_val;
                     state_r <= ST_READ;
                     dcnt_r  <= 5'h00;
                  end
                  else if (kind_n == K_WRITE || kind_n == K_FILL)
                  begin
                     state_r <= ST_DATA;
                     dcnt_r  <= 5'h00;
                  end
                  else
                  begin
                     pend_r  <= kind_n;
                     state_r <= ST_DONE;
                  end
               end
            end
            ST_DATA:
            begin
               data_r <= {data_r[14:0], di_s};
               dcnt_r <= dcnt_r + 5'h01;
               if (dcnt_r == data_bits - 5'h01)
               begin
                  pend_r  <= kind_of(op_w, top_w);
                  state_r <= ST_DONE;
               end
            end
            ST_READ:
               // Last address edge gave the dummy zero; each rise here shifts out the word
               shout_r <= {shout_r[14:0], 1'b0};
            ST_DONE:
               state_r <= ST_DONE;
            default:
               state_r <= ST_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Enable latch and programming timer
   reg [7:0]  cap_addr_r;
   always @(posedge clk_sys)
   begin
      if (rst)
         cap_addr_r <= 8'h00;
      else if (sk_rise && state_r == ST_CMD && cnt_r == addr_bits + 4'd1)
         cap_addr_r <= addr_n;
   end

   integer i;
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         prog_enabled_o <= 1'b0;
         prog_cnt_r     <= 32'd0;
         prog_kind_r    <= K_NONE;
         prog_addr_r    <= 8'h00;
         prog_data_r    <= 16'h0000;
      end
      else
      begin
         if (cs_fall && pend_r == K_EN)
            prog_enabled_o <= 1'b1;
         else if (cs_fall && pend_r == K_LOCK)
            prog_enabled_o <= 1'b0;
         if (cs_fall && prog_kind && prog_enabled_o && ~prog_busy)
         begin
            prog_cnt_r  <= PROG_CYCLES;
            prog_kind_r <= pend_r;
            prog_addr_r <= cap_addr_r;
            prog_data_r <= data_r;
         end
         else if (prog_busy)
            prog_cnt_r <= prog_cnt_r - 32'd1;
      end
   end

   // Array update when the timed cycle ends
   always @(posedge clk_sys)
   begin
      if (prog_cnt_r == 32'd1)
      begin
         for (i = 0; i < DEPTH; i = i + 1)
         begin
            if (prog_kind_r == K_FILL)
               mem_r[i] <= wide ? prog_data_r :
                           {prog_data_r[7:0], prog_data_r[7:0]};
            else if (prog_kind_r == K_CLEAR)
               mem_r[i] <= 16'hffff;
         end
         if (prog_kind_r == K_WRITE || prog_kind_r == K_ERASE)
         begin
            if (wide)
               mem_r[prog_addr_r[6:0]] <= (prog_kind_r == K_ERASE) ?
                                           16'hffff : prog_data_r;
            else if (prog_addr_r[0])
               mem_r[prog_addr_r[7:1]][15:8] <=
                  (prog_kind_r == K_ERASE) ? 8'hff : prog_data_r[7:0];
            else
               mem_r[prog_addr_r[7:1]][7:0] <=
                  (prog_kind_r == K_ERASE) ? 8'hff : prog_data_r[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Output pin and status
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         status_r      <= 1'b0;
         serial_out_o  <= 1'b0;
         serial_out_oe <= 1'b0;
         busy_o        <= 1'b0;
      end
      else
      begin
         busy_o <= prog_busy;
         if (cs_fall && prog_kind && prog_enabled_o && ~prog_busy)
            status_r <= 1'b1;
         // Busy status survives deselects; ready clears once it was shown
         else if ((cs_fall && serial_out_oe && serial_out_o && ~prog_busy) ||
                  (sk_rise && state_r == ST_IDLE && di_s && ~prog_busy))
            status_r <= 1'b0;
         if (~cs_s)
         begin
            serial_out_oe <= 1'b0;
            serial_out_o  <= 1'b0;
         end
         else if (status_r)
         begin
            serial_out_oe <= 1'b1;
            serial_out_o  <= ~prog_busy;
         end
         else if (state_r == ST_READ)
         begin
            // Only rises move the pin; a fall would skip the dummy zero
            serial_out_oe <= 1'b1;
            if (sk_rise)
               serial_out_o <= shout_r[15];
         end
         else if (sk_rise && state_r == ST_CMD &&
                  cnt_r == addr_bits + 4'd1 && op_n == `SEP_OP_READ)
         begin
            serial_out_oe <= 1'b1;
            serial_out_o  <= 1'b0;
         end
         else
            serial_out_oe <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// >>> core/sep_regs.vh
// Constants for the serial EEPROM command port
`ifndef SEP_REGS_VH
`define SEP_REGS_VH
`define SEP_OP_READ     2'b10
`define SEP_OP_WRITE    2'b01
`define SEP_OP_ERASE    2'b11
`define SEP_OP_EXT      2'b00
`define SEP_EXT_ENABLE  2'b11
`define SEP_EXT_FILL    2'b01
`define SEP_EXT_LOCK    2'b00
`define SEP_EXT_CLEAR   2'b10
`define SEP_ADDR_BITS_W 4'd8
`define SEP_ADDR_BITS_B 4'd9
`define SEP_DATA_BITS_W 5'd16
`define SEP_DATA_BITS_B 5'd8
`define SEP_PROG_TIME_US 15000
`define SEP_CLK_MHZ      125
`define SEP_PROG_CYCLES  (`SEP_PROG_TIME_US * `SEP_CLK_MHZ)
`endif

// >>> core/sep_sync.v
// Two-flop synchroniser for a group of pin inputs
`default_nettype none
module sep_sync #(
   parameter W = 3
) (
   // Clock and reset
   input  wire         clk_sys,
   input  wire         rst,
   // Pins in, synchronised out
   input  wire [W-1:0] pin_in,
   output reg  [W-1:0] pin_sync
);
   reg [W-1:0] meta_r;

   // First stage is read only by the second
   always @(posedge clk_sys)
   begin
      if (rst)
      begin
         meta_r   <= {W{1'b0}};
         pin_sync <= {W{1'b0}};
      end
      else
      begin
         meta_r   <= pin_in;
         pin_sync <= meta_r;
      end
   end
endmodule
`default_nettype wire

// >>> verification/sep_core_asserts.sv
// Concurrent checks on the command port pins and status
`default_nettype none
module sep_core_asserts #(
   parameter int PROG_CYCLES = 200
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst,
   // Pins and status
   input wire logic chip_select,
   input wire logic serial_clock,
   input wire logic serial_in,
   input wire logic serial_out_o,
   input wire logic serial_out_oe,
   input wire logic word_width_strap,
   input wire logic busy_o,
   input wire logic prog_enabled_o
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////
   // Busy length counter; a wrong program count shows up here
   int busy_cnt;
   always_ff @(posedge clk_sys)
      busy_cnt <= (rst || !busy_o) ? 0 : busy_cnt + 1;
   ////////////////////////////////////////////////////////////////////////
   a_out_reset: assert property
      (disable iff (1'b0) rst |=> !busy_o && !prog_enabled_o && !serial_out_oe)
      else $error("outputs not cleared by reset");
   a_oe_deselect: assert property (!chip_select [*4] |=> !serial_out_oe)
      else $error("output driven while deselected");
   a_oe_select: assert property ($rose(serial_out_oe) |-> chip_select)
      else $error("output enabled without select");
   a_en_at_fall: assert property
      ($changed(prog_enabled_o) |-> !chip_select && !$past(chip_select))
      else $error("enable latch moved while selected");
   a_busy_enable: assert property ($rose(busy_o) |-> prog_enabled_o)
      else $error("programming started while locked");
   a_busy_launch: assert property ($rose(busy_o) |-> !chip_select)
      else $error("programming started while selected");
   a_busy_length: assert property
      ($fell(busy_o) |-> busy_cnt >= PROG_CYCLES - 2
                         && busy_cnt <= PROG_CYCLES + 2)
      else $error("programming time wrong");
   a_status_busy: assert property
      (busy_o && $past(busy_o, 6) && serial_out_oe |-> !serial_out_o)
      else $error("status not low while busy");
   a_out_on_rise: assert property
      ((chip_select && !serial_clock) [*5] ##1 (chip_select && !serial_clock
       && !busy_o && !$past(busy_o, 3) && $past(serial_out_oe))
       |-> $stable(serial_out_o))
      else $error("output moved without clock rise");
   // Main scenarios reached
   c_prog_done: cover property ($fell(busy_o));
   c_enabled: cover property ($rose(prog_enabled_o));
   c_byte_read: cover property (serial_out_oe && !word_width_strap);
   c_start_bit: cover property (chip_select && serial_in
                                && $rose(serial_clock));
endmodule
bind sep_core sep_core_asserts #(.PROG_CYCLES(PROG_CYCLES)) u_sep_chk (
   .clk_sys(clk_sys), .rst(rst), .chip_select(chip_select),
   .serial_clock(serial_clock), .serial_in(serial_in),
   .serial_out_o(serial_out_o), .serial_out_oe(serial_out_oe),
   .word_width_strap(word_width_strap), .busy_o(busy_o),
   .prog_enabled_o(prog_enabled_o));
`default_nettype wire

// >>> verification/sep_core_tb.sv
// Self-checking bench for the serial EEPROM command port
`default_nettype none
module sep_core_tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int PC = 200;
   logic clk_sys = 1'b0;
   logic rst = 1'b1;
   logic strap = 1'b1;
   logic cs, sclk, sin, so, oe, busy, pen;
   wire logic sout = oe ? so : ~so;
   int bad_count = 0;
   int checks = 0;
   int cyc = 0;
   int seed = 4847;
   logic [15:0] mem [128];
   logic [16:0] q;
   sep_core #(.PROG_CYCLES(PC)) DUT (.clk_sys(clk_sys),
      .rst(rst), .chip_select(cs), .serial_clock(sclk), .serial_in(sin),
      .serial_out_o(so), .serial_out_oe(oe), .word_width_strap(strap),
      .busy_o(busy), .prog_enabled_o(pen));
   sep_master M (.clk_sys(clk_sys), .cs(cs), .sclk(sclk), .sin(sin),
      .sout(sout));
   initial
      forever #4 clk_sys = ~clk_sys;
   ////////////////////////////////////////////////////////////////////////
   task automatic finish_test;
      if (bad_count == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [16:0] got, exp);
      checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Hang guard, well above the planned run length
   always @(posedge clk_sys)
   begin
      cyc++;
      if (cyc == 60000)
      begin
         bad_count++;
         finish_test();
      end
   end
   ////////////////////////////////////////////////////////////////////////
   // One instruction with z leading zeros; p polls status after launch
   task automatic cmd(input logic [1:0] op, input logic [8:0] a,
                      input logic [15:0] d, input int z, input bit p);
      logic [63:0] v;
      int na, nd, r, w;
      na = strap ? 8 : 9;
      nd = (op == 2'b01 || (op == 2'b00 && a[na-1 -: 2] == 2'b01))
         ? (strap ? 16 : 8) : 0;
      r = (op == 2'b10) ? nd + (strap ? 17 : 9) : 0;
      v = (((64'h1 << 2) | op) << na) | (a & ((1 << na) - 1));
      v = (v << nd) | (d & ((1 << nd) - 1));
      M.frame(v, 3 + na + nd + z, r, q);
      // Hold select low so a launch is seen before any status poll
      M.idle(6);
      if (p)
      begin
         M.poll(12);
         chk({busy, oe, sout}, 17'h6);
      end
      w = 0;
      while (busy !== 1'b0 && w < 1000)
      begin
         M.poll(1);
         w++;
      end
      if (p)
      begin
         M.poll(8);
         chk({oe, sout}, 17'h3);
      end
      M.idle(20);
   endtask
   task automatic rd(input logic [8:0] a, input logic [16:0] exp);
      cmd(2'b10, a | (($random(seed) & 1) << (strap ? 7 : 8)), 0, 0, 0);
      chk(q, exp);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [6:0] a;
      logic [15:0] d;
      repeat (20) @(negedge clk_sys);
      rst = 1'b0;
      M.idle(10);
      chk(pen, 0);
      // Clear-all while locked, then poll: neither busy nor status shown
      M.frame(64'h480, 11, 0, q);
      M.poll(12);
      chk({busy, oe}, 0);
      M.idle(20);
      strap = 1'b0;
      cmd(2'b00, 9'h180, 0, 3, 0);
      chk(pen, 1);
      strap = 1'b1;
      cmd(2'b00, 9'h080, 0, 0, 0);
      foreach (mem[i])
         mem[i] = 16'hffff;
      for (int i = 0; i < 3; i++)
      begin
         a = $random(seed);
         d = $random(seed);
         cmd(2'b01, {1'b0, ($random(seed) & 1) != 0, a}, d, 0, i == 0);
         mem[a] = d;
         rd(a, {1'b0, d});
         strap = 1'b0;
         rd({a, 1'b1}, {9'h0, d[15:8]});
         rd({a, 1'b0}, {9'h0, d[7:0]});
         cmd(2'b01, {a, 1'b0}, d + 16'h5a, 0, 0);
         mem[a][7:0] = d[7:0] + 8'h5a;
         strap = 1'b1;
         rd(a, {1'b0, mem[a]});
      end
      cmd(2'b11, a, 0, 0, 0);
      rd(a, 17'h0ffff);
      chk(pen, 1);
      d = $random(seed);
      cmd(2'b00, 9'h040, d, 0, 0);
      a = $random(seed);
      rd(a, {1'b0, d});
      cmd(2'b00, 9'h000, 0, 0, 0);
      chk(pen, 0);
      cmd(2'b01, a, ~d, 0, 0);
      rd(a, {1'b0, d});
      finish_test();
   end
endmodule
`default_nettype wire

// >>> verification/sep_master.sv
// Serial bus master model driving the command port pins
`default_nettype none
module sep_master (
   // Clock
   input  wire logic clk_sys,
   // Pins
   output var  logic cs,
   output var  logic sclk,
   output var  logic sin,
   input  wire logic sout
);
   timeunit 1ns;
   timeprecision 100ps;
   initial
   begin
      cs = 1'b0;
      sclk = 1'b0;
      sin = 1'b0;
   end
   ////////////////////////////////////////////////////////////////////////
   // One bit: data set in low phase, taken at the rise; 80 ns period
   task automatic clk_bit(input logic b);
      sin = b;
      repeat (6) @(negedge clk_sys);
      sclk = 1'b1;
      repeat (4) @(negedge clk_sys);
      sclk = 1'b0;
   endtask
   // Frame: n bits out MSB first, then r bits sampled before each rise
   task automatic frame(input logic [63:0] v, input int n, input int r,
                        output logic [16:0] q);
      q = '0;
      @(negedge clk_sys) cs = 1'b1;
      for (int i = n - 1; i >= 0; i--)
         clk_bit(v[i]);
      for (int i = 0; i < r; i++)
      begin
         repeat (6) @(negedge clk_sys);
         q = {q[15:0], sout};
         sclk = 1'b1;
         repeat (4) @(negedge clk_sys);
         sclk = 1'b0;
      end
      cs = 1'b0;
   endtask
   // Deselected gap; the data line toggles so stale bits never match
   task automatic idle(input int n);
      @(negedge clk_sys) cs = 1'b0;
      repeat (n) @(negedge clk_sys) sin = ~sin;
   endtask
   // Status poll: select with the clock standing still
   task automatic poll(input int k);
      @(negedge clk_sys) cs = 1'b1;
      repeat (k) @(negedge clk_sys);
   endtask
endmodule
`default_nettype wire
